// [logic/hpsd_pkg.sv]
// constants shared by the host port and strap decode block
package hpsd_pkg;
  localparam int unsigned HPSD_CH = 8;
  localparam int unsigned HPSD_HREG_DEPTH = 8;
  localparam int unsigned HPSD_AVM_AW = 5;
  localparam int unsigned HPSD_EV_W = 4;
  ////////////////////////////////////////////////////////////////////////////////
  // avalon register byte offsets
  localparam logic [4:0] HPSD_OFS_STATUS = 5'h00;
  localparam logic [4:0] HPSD_OFS_MASK = 5'h04;
  localparam logic [4:0] HPSD_OFS_CTRL = 5'h08;
  localparam logic [4:0] HPSD_OFS_INFO = 5'h0c;
  localparam logic [4:0] HPSD_OFS_LOOP = 5'h10;
  // status and mask bit positions
  localparam int unsigned HPSD_EV_ALARM = 0;
  localparam int unsigned HPSD_EV_HWR = 1;
  localparam int unsigned HPSD_EV_HRD = 2;
  localparam int unsigned HPSD_EV_MODE = 3;
  // ctrl bit positions and reset values
  localparam int unsigned HPSD_CTRL_SYNC = 0;
  localparam logic [3:0] HPSD_MASK_RST = 4'h0;
  localparam logic HPSD_SYNC_RST = 1'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // host-side register indices and global register fields
  localparam logic [7:0] HPSD_HA_GLOBAL = 8'h00;
  localparam logic [7:0] HPSD_HA_ALARM = 8'h01;
  localparam int unsigned HPSD_GIE_BIT = 0;
  localparam int unsigned HPSD_AUTO_ONES_BIT = 1;
  localparam logic [7:0] HPSD_HREG_RST = 8'h00;
  localparam logic [2:0] HPSD_SER_LAST = 3'h7;
  // loopback select codes
  localparam logic [1:0] HPSD_LB_NONE = 2'h0;
  localparam logic [1:0] HPSD_LB_ANALOG = 2'h1;
  localparam logic [1:0] HPSD_LB_REMOTE = 2'h2;
  localparam logic [1:0] HPSD_LB_DIGITAL = 2'h3;
  ////////////////////////////////////////////////////////////////////////////////
  // bit positions in the synchronised pin vector
  localparam int unsigned HPSD_SY_MODE = 0;
  localparam int unsigned HPSD_SY_SERPAR = 1;
  localparam int unsigned HPSD_SY_WR = 2;
  localparam int unsigned HPSD_SY_RD = 3;
  localparam int unsigned HPSD_SY_ALE = 4;
  localparam int unsigned HPSD_SY_CS = 5;
  localparam int unsigned HPSD_SY_RDY = 6;
  localparam int unsigned HPSD_SY_UPCLK = 7;
  localparam int unsigned HPSD_SY_ADDR = 8;
  localparam int unsigned HPSD_SY_DATA = 16;
  localparam int unsigned HPSD_SY_W = 24;
endpackage

// [logic/hpsd_sync.sv]
// two flip-flop synchroniser for a vector of pin levels
module hpsd_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // bits are independent levels; a multi-bit pin group may skew by a cycle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_r <= '0;
      o_q <= '0;
    end else begin
      meta_r <= i_d;
      o_q <= meta_r;
    end
  end
endmodule

// [logic/hpsd_host_port.sv]
// host port, strap decode and avalon register slave of the line interface unit
module hpsd_host_port
  import hpsd_pkg::*;
#(
  parameter int unsigned HREG_DEPTH = HPSD_HREG_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_mode_select_pin,
  input wire logic i_serial_parallel_select,
  input wire logic i_wr_n,
  input wire logic i_read_data_strobe_n,
  input wire logic i_ale,
  input wire logic i_cs_n,
  input wire logic i_rdy,
  input wire logic i_upclk,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic [HPSD_CH-1:0] i_los,
  input wire logic [HPSD_CH-1:0] i_alarm,
  input wire logic [HPSD_AVM_AW-1:0] i_avm_address,
  input wire logic i_avm_read,
  input wire logic i_avm_write,
  input wire logic [31:0] i_avm_writedata,
  input wire logic [3:0] i_avm_byteenable,
  output logic [31:0] o_avm_readdata,
  output logic o_avm_waitrequest,
  output logic o_irq,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_rdy,
  output logic o_rdy_oe,
  output logic o_int_n,
  output logic o_int_n_oe,
  output logic [2*HPSD_CH-1:0] o_loop_code,
  output logic [HPSD_CH-1:0] o_lb_analog,
  output logic [HPSD_CH-1:0] o_lb_remote,
  output logic [HPSD_CH-1:0] o_lb_digital,
  output logic [4:0] o_equalizer_code,
  output logic o_auto_ones_on_los,
  output logic [HPSD_CH-1:0] o_line_tx_all_ones
);
  localparam int unsigned IW = $clog2(HREG_DEPTH);

  typedef enum logic [1:0] {HP_IDLE, HP_ACK, HP_SHIFT} hpsd_hp_type;

  logic [HPSD_SY_W-1:0] s;
  logic host_mode_r, serpar_r, upclk_d_r, ale_d_r, sync_mode_r, is_read_r;
  logic [1:0] settle_r;
  logic upclk_rise, ale_fall, upd, sel, wr_go, rd_go, rel, hit, rd_alarm, global_irq_enable, auto_sel;
  logic [7:0] addr_lat_r, rdata_r, rd_val;
  logic [7:0] hreg_r [HREG_DEPTH];
  logic [IW-1:0] hidx;
  logic [2:0] bit_cnt_r;
  logic [HPSD_CH-1:0] alarm_prev_r, alarm_chg_r, chg_set;
  hpsd_hp_type hp_state_r;
  logic [2*HPSD_CH-1:0] loop_pins;
  logic [4:0] eq_pins;
  logic [HPSD_EV_W-1:0] status_r, mask_r, ev;
  logic avm_req, avm_acc, stat_clr;
  logic [31:0] avm_val;

  ////////////////////////////////////////////////////////////////////////////////
  // pins cross into the clock domain before anything looks at them
  hpsd_sync #(.W(HPSD_SY_W)) u_sync (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_d({i_data, i_addr, i_upclk, i_rdy, i_cs_n, i_ale, i_read_data_strobe_n, i_wr_n,
          i_serial_parallel_select, i_mode_select_pin}),
    .o_q(s)
  );

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      settle_r <= 2'h0;
      host_mode_r <= 1'b0;
      serpar_r <= 1'b0;
      upclk_d_r <= 1'b0;
      ale_d_r <= 1'b0;
    end else begin
      // synced pins read zero for two edges after reset; stay in hardware mode till valid
      settle_r <= {settle_r[0], 1'b1};
      host_mode_r <= settle_r[1] && !s[HPSD_SY_MODE];
      serpar_r <= s[HPSD_SY_SERPAR];
      upclk_d_r <= s[HPSD_SY_UPCLK];
      ale_d_r <= s[HPSD_SY_ALE];
    end
  end

  assign upclk_rise = s[HPSD_SY_UPCLK] && !upclk_d_r;
  assign ale_fall = ale_d_r && !s[HPSD_SY_ALE];

  ////////////////////////////////////////////////////////////////////////////////
  // host access decode
  assign upd = sync_mode_r ? upclk_rise : 1'b1;
  assign sel = host_mode_r && !s[HPSD_SY_CS] && upd;
  assign wr_go = (hp_state_r == HP_IDLE) && sel && !s[HPSD_SY_WR];
  assign rd_go = (hp_state_r == HP_IDLE) && sel && !s[HPSD_SY_RD] && s[HPSD_SY_WR];
  assign rel = s[HPSD_SY_CS] || (s[HPSD_SY_WR] && s[HPSD_SY_RD]);
  assign hit = addr_lat_r < 8'(HREG_DEPTH);
  assign hidx = addr_lat_r[IW-1:0];
  assign rd_alarm = rd_go && (addr_lat_r == HPSD_HA_ALARM);
  assign rd_val = (addr_lat_r == HPSD_HA_ALARM) ? alarm_chg_r : (hit ? hreg_r[hidx] : 8'h00);
  assign global_irq_enable = hreg_r[HPSD_HA_GLOBAL[IW-1:0]][HPSD_GIE_BIT];

  // latch only on the falling edge so a slow strobe still catches settled address
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_lat_r <= 8'h00;
    end else if (host_mode_r && ale_fall) begin
      addr_lat_r <= s[HPSD_SY_ADDR +: 8];
    end
  end

  // the alarm index has no storage of its own; writes to it are dropped
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int i = 0; i < HREG_DEPTH; i++) begin
        hreg_r[i] <= HPSD_HREG_RST;
      end
    end else if (wr_go && hit && (addr_lat_r != HPSD_HA_ALARM)) begin
      hreg_r[hidx] <= s[HPSD_SY_DATA +: 8];
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hp_state_r <= HP_IDLE;
      rdata_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      is_read_r <= 1'b0;
    end else if (!host_mode_r) begin
      hp_state_r <= HP_IDLE;
    end else begin
      case (hp_state_r)
        HP_IDLE: begin
          if (wr_go) begin
            is_read_r <= 1'b0;
            hp_state_r <= HP_ACK;
          end else if (rd_go) begin
            is_read_r <= 1'b1;
            rdata_r <= rd_val;
            bit_cnt_r <= HPSD_SER_LAST;
            hp_state_r <= serpar_r ? HP_SHIFT : HP_ACK;
          end
        end
        HP_SHIFT: begin
          if (s[HPSD_SY_CS]) begin
            hp_state_r <= HP_IDLE;
          end else if (upclk_rise) begin
            if (bit_cnt_r == 3'h0) begin
              hp_state_r <= HP_ACK;
            end else begin
              bit_cnt_r <= bit_cnt_r - 3'h1;
            end
          end
        end
        HP_ACK: begin
          if (rel) begin
            hp_state_r <= HP_IDLE;
          end
        end
        default: begin
          hp_state_r <= HP_IDLE;
        end
      endcase
    end
  end

  // pin drivers; in hardware mode the rdy and data pins stay inputs
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdy <= 1'b0;
      o_rdy_oe <= 1'b0;
      o_data <= 8'h00;
      o_data_oe <= 1'b0;
    end else begin
      o_rdy <= ((hp_state_r == HP_ACK) && !serpar_r) ||
               ((hp_state_r == HP_SHIFT) && rdata_r[bit_cnt_r]);
      o_rdy_oe <= host_mode_r && !s[HPSD_SY_CS];
      o_data <= rdata_r;
      o_data_oe <= host_mode_r && (hp_state_r == HP_ACK) && is_read_r && !serpar_r && !rel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // alarm change status and open-drain interrupt pin
  assign chg_set = i_alarm ^ alarm_prev_r;

  // a change landing on the clearing read survives
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      alarm_prev_r <= '0;
      alarm_chg_r <= '0;
    end else begin
      alarm_prev_r <= i_alarm;
      alarm_chg_r <= (alarm_chg_r & ~(rd_alarm ? rd_val : 8'h00)) | chg_set;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_int_n <= 1'b0;
      o_int_n_oe <= 1'b0;
    end else begin
      o_int_n <= 1'b0;
      o_int_n_oe <= host_mode_r && global_irq_enable && (|alarm_chg_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // hardware mode straps
  assign eq_pins = {s[HPSD_SY_RDY], s[HPSD_SY_CS], s[HPSD_SY_ALE], s[HPSD_SY_RD], s[HPSD_SY_WR]};
  assign auto_sel = host_mode_r ? hreg_r[HPSD_HA_GLOBAL[IW-1:0]][HPSD_AUTO_ONES_BIT]
                                : s[HPSD_SY_UPCLK];

  for (genvar c = 0; c < HPSD_CH / 2; c++) begin : g_pinmap
    assign loop_pins[2*c +: 2] = s[HPSD_SY_ADDR + 2*c +: 2];
    assign loop_pins[2*(c + 4) +: 2] = s[HPSD_SY_DATA + 6 - 2*c +: 2];
  end

  // straps are held when host mode is entered, so outputs never follow bus traffic
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_loop_code <= {HPSD_CH{HPSD_LB_NONE}};
      o_equalizer_code <= 5'h00;
    end else if (!host_mode_r && s[HPSD_SY_MODE]) begin
      o_loop_code <= loop_pins;
      o_equalizer_code <= eq_pins;
    end
  end

  for (genvar c = 0; c < HPSD_CH; c++) begin : g_lb
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        o_lb_analog[c] <= 1'b0;
        o_lb_remote[c] <= 1'b0;
        o_lb_digital[c] <= 1'b0;
      end else if (!host_mode_r && s[HPSD_SY_MODE]) begin
        o_lb_analog[c] <= loop_pins[2*c +: 2] == HPSD_LB_ANALOG;
        o_lb_remote[c] <= loop_pins[2*c +: 2] == HPSD_LB_REMOTE;
        o_lb_digital[c] <= loop_pins[2*c +: 2] == HPSD_LB_DIGITAL;
      end
    end
    AST_LOOP_DECODE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
      o_lb_remote[c] == (o_loop_code[2*c +: 2] == HPSD_LB_REMOTE) &&
      o_lb_digital[c] == (o_loop_code[2*c +: 2] == HPSD_LB_DIGITAL))
      else $error("loopback decode does not match loop code");
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_auto_ones_on_los <= 1'b0;
      o_line_tx_all_ones <= '0;
    end else begin
      o_auto_ones_on_los <= auto_sel;
      o_line_tx_all_ones <= {HPSD_CH{auto_sel}} & i_los;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then one cycle with waitrequest low
  assign avm_req = i_avm_read || i_avm_write;
  assign avm_acc = avm_req && !o_avm_waitrequest;
  assign stat_clr = avm_acc && i_avm_read && (i_avm_address == HPSD_OFS_STATUS);
  assign ev = {settle_r[1] && (host_mode_r ^ !s[HPSD_SY_MODE]), rd_go, wr_go, |chg_set};

  always_comb begin
    avm_val = 32'h0000_0000;
    case (i_avm_address)
      HPSD_OFS_STATUS: avm_val[HPSD_EV_W-1:0] = status_r;
      HPSD_OFS_MASK: avm_val[HPSD_EV_W-1:0] = mask_r;
      HPSD_OFS_CTRL: avm_val[HPSD_CTRL_SYNC] = sync_mode_r;
      HPSD_OFS_INFO: avm_val[15:0] = {alarm_chg_r, o_equalizer_code, serpar_r, global_irq_enable,
                                      host_mode_r};
      HPSD_OFS_LOOP: avm_val[2*HPSD_CH-1:0] = o_loop_code;
      default: avm_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avm_waitrequest <= 1'b1;
      o_avm_readdata <= 32'h0000_0000;
    end else begin
      o_avm_waitrequest <= !(avm_req && o_avm_waitrequest);
      if (avm_req && o_avm_waitrequest) begin
        o_avm_readdata <= avm_val;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mask_r <= HPSD_MASK_RST;
      sync_mode_r <= HPSD_SYNC_RST;
    end else if (avm_acc && i_avm_write && i_avm_byteenable[0]) begin
      if (i_avm_address == HPSD_OFS_MASK) begin
        mask_r <= i_avm_writedata[HPSD_EV_W-1:0];
      end
      if (i_avm_address == HPSD_OFS_CTRL) begin
        sync_mode_r <= i_avm_writedata[HPSD_CTRL_SYNC];
      end
    end
  end

  // only bits already shown to software are cleared, so nothing slips between
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      status_r <= '0;
      o_irq <= 1'b0;
    end else begin
      status_r <= (status_r & ~(stat_clr ? o_avm_readdata[HPSD_EV_W-1:0] : 4'h0)) | ev;
      o_irq <= |(status_r & mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  AST_HW_PINS_IDLE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !host_mode_r |=> !o_data_oe && !o_rdy_oe)
    else $error("bus pins driven in hardware mode");
  AST_INT_NEEDS_GIE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_int_n_oe |-> $past(global_irq_enable))
    else $error("interrupt without global enable");
  AST_INT_OPEN_DRAIN: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_int_n == 1'b0)
    else $error("interrupt pin driven high");
  AST_INT_ON_CHANGE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (chg_set != '0) ##1 (host_mode_r && global_irq_enable) |=> o_int_n_oe)
    else $error("alarm change did not pull interrupt low");
  AST_INT_RELEASE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    rd_alarm && (chg_set == '0) |=> alarm_chg_r == '0 ##1 !o_int_n_oe || $past(chg_set) != '0)
    else $error("status read did not release interrupt");
  AST_ADDR_LATCH: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    host_mode_r && ale_fall |=> addr_lat_r == $past(s[HPSD_SY_ADDR +: 8]))
    else $error("address not latched on strobe");
  AST_RDY_PAR: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    wr_go && !serpar_r ##1 !serpar_r |=> o_rdy)
    else $error("ready missing after parallel write");
  AST_SYNC_QUAL: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    sync_mode_r && !upclk_rise && hp_state_r == HP_IDLE |=> hp_state_r == HP_IDLE)
    else $error("access taken without host clock edge");
  AST_EQ_PASS: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    !host_mode_r && s[HPSD_SY_MODE] |=> o_equalizer_code == $past(eq_pins))
    else $error("equalizer code not passed through");
  AST_ALL_ONES: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    (o_line_tx_all_ones & ~$past(i_los)) == '0 && (o_line_tx_all_ones == '0 || o_auto_ones_on_los))
    else $error("all ones sent without loss of signal");
  AST_READ_DRIVE: assert property (@(posedge i_mclk) disable iff (!i_arst_n)
    o_data_oe |-> $past(is_read_r) && $past(host_mode_r))
    else $error("data bus driven outside a read");
endmodule

// [test/hpsd_host_model.sv]
// behavioural local microprocessor that drives the shared host pins
module hpsd_host_model (
  input wire logic i_mclk,
  input wire logic i_rdy_pin,
  input wire logic [7:0] i_data_pin,
  output logic o_wr_n,
  output logic o_rd_n,
  output logic o_ale,
  output logic o_cs_n,
  output logic o_rdy,
  output logic o_rdy_en,
  output logic o_upclk,
  output logic [7:0] o_addr,
  output logic [7:0] o_data,
  output logic o_data_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_run = 1'b0;
  initial begin
    {o_wr_n, o_rd_n, o_ale, o_cs_n, o_rdy, o_rdy_en, o_upclk, o_data_en} = 8'h00;
    {o_addr, o_data} = 16'h0000;
  end
  // host clock runs free in host mode, frozen as a strap level in hardware mode
  always #80 if (clk_run) o_upclk <= ~o_upclk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic straps(input logic [7:0] a, input logic [7:0] d, input logic [4:0] eq,
                        input logic ao);
    clk_run <= 1'b0;
    {o_addr, o_data, o_data_en, o_rdy_en, o_upclk} <= {a, d, 2'h3, ao};
    {o_rdy, o_cs_n, o_ale, o_rd_n, o_wr_n} <= eq;
  endtask
  task automatic to_host();
    {o_rdy_en, o_data_en, o_ale, o_wr_n, o_rd_n, o_cs_n} <= 6'h07;
    clk_run <= 1'b1;
  endtask
  // address phase: select, present address, latch on the falling strobe
  task automatic latch(input logic [7:0] a);
    {o_addr, o_cs_n, o_ale} <= {a, 2'h1};
    repeat (4) @(posedge i_mclk);
    o_ale <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    int n;
    latch(a);
    {o_data, o_data_en, o_wr_n, o_rd_n} <= {d, wr, ~wr, wr};
    n = 0;
    do begin @(posedge i_mclk); n++; end while (i_rdy_pin !== 1'b1 && n < 60);
    q = i_data_pin;
    ok = (n < 60);
    {o_wr_n, o_rd_n, o_cs_n, o_data_en} <= 4'he;
    n = 0;
    do begin @(posedge i_mclk); n++; end while (i_rdy_pin !== 1'b0 && n < 60);
    ok = ok && (n < 60);
    repeat (2) @(posedge i_mclk);
  endtask
  // serial readback: sample the ready pin mid-bit, away from the shifting edge
  task automatic serial(input logic [7:0] a, output logic [11:0] s);
    latch(a);
    o_rd_n <= 1'b0;
    s = 12'h000;
    for (int i = 0; i < 12; i++) begin
      @(negedge o_upclk);
      s = {s[10:0], i_rdy_pin};
    end
    @(posedge i_mclk);
    {o_rd_n, o_cs_n} <= 2'h3;
    repeat (8) @(posedge i_mclk);
  endtask
endmodule

// [test/hpsd_host_port_tb.sv]
// self-checking bench of the host port and strap decode block
module hpsd_host_port_tb;
  import hpsd_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0] a; logic [7:0] d; logic [4:0] eq; logic ao; logic [7:0] los; logic [15:0] lc;
  } hpsd_row_type;
  localparam hpsd_row_type ROWS [4] = '{
    '{8'he4, 8'h1b, 5'h15, 1'b1, 8'h5a, 16'he4e4},
    '{8'h1b, 8'he4, 5'h0a, 1'b0, 8'hff, 16'h1b1b},
    '{8'hff, 8'h00, 5'h1f, 1'b1, 8'h81, 16'h00ff},
    '{8'h00, 8'hff, 5'h00, 1'b0, 8'h00, 16'hff00}};
  logic mclk = 1'b0;
  logic arst_n, mode, serpar, av_rd, av_wr;
  logic [7:0] los, alarm, q, an, re, di;
  logic [4:0] av_a;
  logic [31:0] av_wd, d;
  logic [3:0] av_be;
  logic [11:0] s;
  logic ok, found;
  int n_mismatch = 0;
  int tests_run = 0;
  logic m_wr_n, m_rd_n, m_ale, m_cs_n, m_rdy, m_rdy_en, m_upclk, m_den;
  logic [7:0] m_addr, m_data, o_data;
  logic [31:0] o_avm_readdata;
  logic o_avm_waitrequest, o_irq, o_data_oe, o_rdy, o_rdy_oe, o_int_n, o_int_n_oe, o_ao;
  logic [15:0] o_loop_code;
  logic [7:0] o_lb_analog, o_lb_remote, o_lb_digital, o_tx1;
  logic [4:0] o_eq;
  // both shared pins are pulled low when nobody drives them
  wire logic rdy_pin = m_rdy_en ? m_rdy : (o_rdy_oe ? o_rdy : 1'b0);
  wire logic [7:0] data_pin = m_den ? m_data : (o_data_oe ? o_data : 8'h00);
  always #5 mclk = ~mclk;
  hpsd_host_model hm (.i_mclk(mclk), .i_rdy_pin(rdy_pin), .i_data_pin(data_pin),
    .o_wr_n(m_wr_n), .o_rd_n(m_rd_n), .o_ale(m_ale), .o_cs_n(m_cs_n), .o_rdy(m_rdy),
    .o_rdy_en(m_rdy_en), .o_upclk(m_upclk), .o_addr(m_addr), .o_data(m_data),
    .o_data_en(m_den));
  hpsd_host_port dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_mode_select_pin(mode),
    .i_serial_parallel_select(serpar), .i_wr_n(m_wr_n), .i_read_data_strobe_n(m_rd_n),
    .i_ale(m_ale), .i_cs_n(m_cs_n), .i_rdy(rdy_pin), .i_upclk(m_upclk), .i_addr(m_addr),
    .i_data(data_pin), .i_los(los), .i_alarm(alarm), .i_avm_address(av_a),
    .i_avm_read(av_rd), .i_avm_write(av_wr), .i_avm_writedata(av_wd),
    .i_avm_byteenable(av_be), .o_avm_readdata(o_avm_readdata),
    .o_avm_waitrequest(o_avm_waitrequest), .o_irq(o_irq), .o_data(o_data),
    .o_data_oe(o_data_oe), .o_rdy(o_rdy), .o_rdy_oe(o_rdy_oe), .o_int_n(o_int_n),
    .o_int_n_oe(o_int_n_oe), .o_loop_code(o_loop_code), .o_lb_analog(o_lb_analog),
    .o_lb_remote(o_lb_remote), .o_lb_digital(o_lb_digital), .o_equalizer_code(o_eq),
    .o_auto_ones_on_los(o_ao), .o_line_tx_all_ones(o_tx1));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] wd,
                    input logic [3:0] be, output logic [31:0] rd);
    int n;
    {av_a, av_wd, av_be, av_wr, av_rd} <= {a, wd, be, wr, ~wr};
    n = 0;
    do begin @(posedge mclk); n++; end while (o_avm_waitrequest !== 1'b0 && n < 20);
    rd = o_avm_readdata;
    {av_wr, av_rd} <= 2'h0;
    if (n >= 20) n_mismatch++;
    @(posedge mclk);
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // the whole run is well under 1000 cycles; this is a wide margin over it
  initial begin
    #300us;
    n_mismatch++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {arst_n, mode, serpar, av_rd, av_wr, los, alarm, av_a, av_wd, av_be} = {3'h2, 59'h0};
    repeat (8) @(posedge mclk);
    check("rst", {o_avm_waitrequest, o_irq, o_int_n_oe, o_rdy_oe, o_data_oe}, 5'h10);
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    foreach (ROWS[i]) begin
      hm.straps(ROWS[i].a, ROWS[i].d, ROWS[i].eq, ROWS[i].ao);
      los <= ROWS[i].los;
      repeat (10) @(posedge mclk);
      for (int c = 0; c < 8; c++) begin
        an[c] = (ROWS[i].lc[2*c+:2] == HPSD_LB_ANALOG);
        re[c] = (ROWS[i].lc[2*c+:2] == HPSD_LB_REMOTE);
        di[c] = (ROWS[i].lc[2*c+:2] == HPSD_LB_DIGITAL);
      end
      check("loop", o_loop_code, ROWS[i].lc);
      check("lbdec", {o_lb_analog, o_lb_remote, o_lb_digital}, {an, re, di});
      check("eq", o_eq, ROWS[i].eq);
      check("aones", {o_ao, o_tx1}, {ROWS[i].ao, ROWS[i].ao ? ROWS[i].los : 8'h00});
      check("hwint", o_int_n_oe, 1'b0);
    end
    av(0, HPSD_OFS_MASK, 0, 4'hf, d);
    check("mask", d, {28'h0, HPSD_MASK_RST});
    av(1, HPSD_OFS_MASK, 32'hf, 4'h0, d);
    av(0, HPSD_OFS_MASK, 0, 4'hf, d);
    check("mask be", d, 32'h0);
    av(1, HPSD_OFS_LOOP, 32'h0, 4'hf, d);
    av(0, HPSD_OFS_LOOP, 0, 4'hf, d);
    check("loop ro", d, 32'h0000ff00);
    av(0, 5'h14, 0, 4'hf, d);
    check("unmapped", d, 32'h0);
    mode <= 1'b0;
    hm.to_host();
    repeat (10) @(posedge mclk);
    hm.access(1, 8'h02, 8'ha5, q, ok);
    check("wr done", ok, 1'b1);
    hm.access(0, 8'h02, 8'h00, q, ok);
    check("rd", {ok, q}, 9'h1a5);
    hm.access(0, 8'h09, 8'h00, q, ok);
    check("rd none", q, 8'h00);
    check("frozen", o_loop_code, 16'hff00);
    alarm <= 8'h01;
    repeat (6) @(posedge mclk);
    check("no gie", o_int_n_oe, 1'b0);
    hm.access(0, HPSD_HA_ALARM, 8'h00, q, ok);
    check("alarm", q, 8'h01);
    hm.access(1, HPSD_HA_GLOBAL, 8'h03, q, ok);
    los <= 8'h3c;
    repeat (4) @(posedge mclk);
    check("host aones", {o_ao, o_tx1}, 9'h13c);
    alarm <= 8'h03;
    repeat (4) @(posedge mclk);
    check("int", {o_int_n_oe, o_int_n}, 2'h2);
    hm.access(0, HPSD_HA_ALARM, 8'h00, q, ok);
    check("alarm2", q, 8'h02);
    repeat (3) @(posedge mclk);
    check("int rel", o_int_n_oe, 1'b0);
    av(0, HPSD_OFS_INFO, 0, 4'hf, d);
    check("info", d, 32'h0000_0003);
    av(0, HPSD_OFS_STATUS, 0, 4'hf, d);
    alarm <= 8'h07;
    repeat (4) @(posedge mclk);
    check("irq mask", o_irq, 1'b0);
    av(1, HPSD_OFS_MASK, 32'h1, 4'h1, d);
    repeat (3) @(posedge mclk);
    check("irq", o_irq, 1'b1);
    av(0, HPSD_OFS_STATUS, 0, 4'hf, d);
    check("status", d, 32'h1);
    repeat (3) @(posedge mclk);
    check("irq clr", o_irq, 1'b0);
    av(1, HPSD_OFS_CTRL, 32'h1, 4'hf, d);
    hm.access(1, 8'h03, 8'h3c, q, ok);
    hm.access(0, 8'h03, 8'h00, q, ok);
    check("sync rd", {ok, q}, 9'h13c);
    serpar <= 1'b1;
    repeat (10) @(posedge mclk);
    hm.serial(8'h02, s);
    found = 1'b0;
    // phase of the first sample is free; bits outside the byte must read idle low
    for (int i = 0; i < 5; i++) if (s === (12'h0a5 << i)) found = 1'b1;
    check("serial", found, 1'b1);
    final_report();
  end
endmodule
